// ### shared/codec_defs.svh
// Register offsets, field positions, reset values and counts of the infrared codec.
// Assumes inclusion by bare name from the codec's design files.
`ifndef CODEC_DEFS_SVH
`define CODEC_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFF_EVENT_SOURCE 2'h0
`define OFF_TX_PULSE_LENGTH 2'h1
`define OFF_RX_FILTER_LENGTH 2'h2

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define SOURCE_SEL_MSB 3
`define SOURCE_SEL_CH_BIT 3
`define EVENT_SOURCE_RST 4'h0
`define LENGTH_RST 8'h00

// ---------------------------------------------------------------
// Modes and counts
// ---------------------------------------------------------------
`define MODE_INFRARED 2'h2
`define TXLEN_THREE_16 8'h00
`define TXLEN_BYPASS 8'hFF
`define THREE_16_TICKS 8'h03
`define BIT_TICKS_NORMAL 5'h10
`define BIT_TICKS_DOUBLE 5'h08

`endif

// ### shared/codec_pkg.sv
// Types shared by the infrared codec modules.
// Assumes codec_defs.svh for all numeric constants.
`default_nettype none
package codec_pkg;

  // Transmit pulse shaper states
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_PULSE = 1'b1
  } tx_state_e;

  // Transmit shaper state
  typedef struct packed {
    tx_state_e state;
    logic [4:0] phase;
    logic [7:0] cnt;
    logic txd_prev;
    logic pulse;
  } shaper_state_s;

  // Receive filter state
  typedef struct packed {
    logic prev;
    logic [7:0] run;
    logic filt;
    logic [4:0] hold;
    logic dec;
  } filter_state_s;

  // Top level state
  typedef struct packed {
    logic [3:0] src_sel;
    logic [7:0] tx_len;
    logic [7:0] rx_len;
    logic [7:0] rd_data;
    logic rx_meta;
    logic rx_sync;
    logic tx_pin;
    logic usart_rxd;
  } top_state_s;

  // Saturating 8-bit increment
  function automatic logic [7:0] step8(input logic [7:0] v);
    step8 = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

endpackage
`default_nettype wire

// ### shared/codec_link_if.sv
// Configuration and timing carried from the codec top to its shaper and filter.
// Assumes all signals are driven on clk by the top module.
`default_nettype none
interface codec_link_if;
  logic active;            // Infrared mode selected
  logic [7:0] tx_len;      // Transmit pulse length setting
  logic [7:0] rx_len;      // Receive filter setting
  logic [4:0] bit_ticks;   // Baud ticks per bit
  logic baud_tick;         // Rising edge of baud-rate clock

  modport drive (output active, output tx_len, output rx_len, output bit_ticks, output baud_tick);
  modport shaper (input active, input tx_len, input bit_ticks, input baud_tick);
  modport filter (input active, input rx_len, input bit_ticks, input baud_tick);
endinterface
`default_nettype wire

// ### verilog/ir_tx_shaper.sv
// Transmit pulse shaper: turns low serial bits into high infrared pulses.
// Assumes usart_txd and baud_tick on clk; output is the pulse, before pin inversion.
`include "codec_defs.svh"
`default_nettype none
module ir_tx_shaper (
  input wire logic clk,
  input wire logic sys_rst,
  codec_link_if.shaper link,
  input wire logic usart_txd,
  output logic tx_pulse
);
  import codec_pkg::*;

  shaper_state_s s;       // Registered state
  shaper_state_s next_s;  // Next state
  logic start;            // Bit start on baud edge
  logic mode_316;         // Three-sixteenths mode

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.txd_prev = usart_txd;
    mode_316 = (link.tx_len == `TXLEN_THREE_16);
    // Bit phase follows baud ticks, restarted by a start bit edge
    if (s.txd_prev && !usart_txd) begin
      next_s.phase = 5'h00;
    end else if (link.baud_tick) begin
      next_s.phase = (s.phase >= link.bit_ticks - 5'h01) ? 5'h00 : s.phase + 5'h01;
    end
    start = link.baud_tick && !usart_txd && (s.phase == 5'h00);
    case (s.state)
      TX_IDLE: begin
        if (start) begin
          next_s.state = TX_PULSE;
          next_s.cnt = mode_316 ? 8'h00 : 8'h01;
        end
      end
      TX_PULSE: begin
        if (mode_316) begin
          // Count baud ticks up to three of sixteen
          if (link.baud_tick) begin
            next_s.cnt = step8(s.cnt);
          end
          if (next_s.cnt >= `THREE_16_TICKS) begin
            next_s.state = TX_IDLE;
          end
        end else if (s.cnt >= link.tx_len) begin
          next_s.state = TX_IDLE;
        end else begin
          next_s.cnt = step8(s.cnt);
        end
      end
      default: begin
        next_s.state = TX_IDLE;
      end
    endcase
    // Idle outside infrared mode and in bypass
    if (!link.active || link.tx_len == `TXLEN_BYPASS) begin
      next_s.state = TX_IDLE;
    end
    next_s.pulse = (next_s.state == TX_PULSE);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '{state: TX_IDLE, phase: 5'h00, cnt: 8'h00, txd_prev: 1'b1, pulse: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign tx_pulse = s.pulse;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [7:0] width_cyc;   // Cycles the pulse has been high
  logic [7:0] width_tick;  // Baud ticks while high
  always_ff @(posedge clk) begin
    if (sys_rst || !s.pulse) begin
      width_cyc <= s.pulse ? 8'h01 : 8'h00;
      width_tick <= 8'h00;
    end else begin
      width_cyc <= step8(width_cyc);
      width_tick <= link.baud_tick ? step8(width_tick) : width_tick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  fixed_width_a: assert property ($fell(s.pulse) && link.tx_len != 8'h00 && $stable(link.tx_len)
    |-> width_cyc == link.tx_len) else $error("fixed pulse width wrong");
  three_16_a: assert property ($fell(s.pulse) && link.tx_len == 8'h00 && link.active
    |-> width_tick == 8'h03) else $error("three-sixteenths pulse wrong");
  edge_align_a: assert property ($rose(s.pulse) |-> $past(link.baud_tick)) else $error("pulse not on baud edge");
  fixed_cov: cover property ($fell(s.pulse) && link.tx_len == 8'h04);
  three_cov: cover property ($fell(s.pulse) && link.tx_len == 8'h00);
endmodule
`default_nettype wire

// ### verilog/ir_rx_filter.sv
// Receive filter and decoder: equal-sample filter, then one bit of low output per pulse.
// Assumes ir_level is already synchronised to clk, high while a pulse is present.
`include "codec_defs.svh"
`default_nettype none
module ir_rx_filter (
  input wire logic clk,
  input wire logic sys_rst,
  codec_link_if.filter link,
  input wire logic ir_level,
  output logic rx_bit
);
  import codec_pkg::*;

  filter_state_s s;       // Registered state
  filter_state_s next_s;  // Next state

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.prev = ir_level;
    // Run length of equal samples, minus one
    next_s.run = (ir_level == s.prev) ? step8(s.run) : 8'h00;
    if (next_s.run >= link.rx_len) begin
      next_s.filt = ir_level;
    end
    // Stretch an accepted pulse to a full bit
    if (next_s.filt && !s.filt) begin
      next_s.hold = link.bit_ticks;
    end else if (link.baud_tick && s.hold != 5'h00) begin
      next_s.hold = s.hold - 5'h01;
    end
    // Accepted pulse is zero, no pulse is one
    next_s.dec = !(next_s.filt || next_s.hold != 5'h00);
    if (!link.active) begin
      next_s.run = 8'h00;
      next_s.filt = 1'b0;
      next_s.hold = 5'h00;
      next_s.dec = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '{prev: 1'b0, run: 8'h00, filt: 1'b0, hold: 5'h00, dec: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign rx_bit = s.dec;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  filter_run_a: assert property ($changed(s.filt) && link.active |-> s.run >= link.rx_len)
    else $error("filter accepted too early");
  pulse_zero_a: assert property (s.filt |-> !s.dec) else $error("pulse not decoded as zero");
  no_filter_a: assert property (link.active && link.rx_len == 8'h00 |=> s.filt == $past(ir_level))
    else $error("unfiltered input not followed");
  rx_cov: cover property ($rose(s.filt) && link.rx_len != 8'h00);
endmodule
`default_nettype wire

// ### verilog/infrared_codec.sv
// Infrared codec top: registers, pin routing, event input and the two pulse engines.
// Assumes one serial port's mode, transmit and receive lines and baud tick on clk;
// the receive pin is asynchronous and passes two flip-flops first.
//
// Summary of operation
// - Infrared mode routes port lines through codec
// - Pin levels are inverse of the pulse
// - Selected event channel replaces the receive pin
// - Setting zero gives three-sixteenths bit pulses
// - Setting 1 to 254 gives clock-count pulses
// - Fixed pulses start on baud clock edge
// - Setting 255 passes both lines unaltered
// - Settings inert while infrared mode unselected
// - Filter x needs x+1 equal samples
// - Accepted pulse is zero, no pulse is one
// - Event select 1nnn picks channel nnn
// - Control upper four bits read zero
// - Supports infrared signalling up to 115.2 kbit/s
// - Bit divisor sixteen, eight with double speed
`include "codec_defs.svh"
`default_nettype none
module infrared_codec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [1:0] comm_mode_select,
  input wire logic double_speed,
  input wire logic baud_tick,
  input wire logic usart_txd,
  output logic usart_rxd,
  output logic tx_pin,
  input wire logic rx_pin,
  input wire logic [7:0] event_channel_n
);
  import codec_pkg::*;

  top_state_s s;        // Registered state
  top_state_s next_s;   // Next state
  codec_link_if link(); // Link to shaper and filter
  logic tx_pulse;       // Pulse from shaper
  logic rx_bit;         // Decoded bit from filter
  logic rx_src;         // Selected receive source
  logic ev_sel;         // Event channel selected
  logic bypass;         // Pulse coding off

  // ---------------------------------------------------------------
  // Link drive
  // ---------------------------------------------------------------
  // Only one port may feed this input at once
  assign link.active = (comm_mode_select == `MODE_INFRARED);
  assign link.tx_len = s.tx_len;
  assign link.rx_len = s.rx_len;
  // Bit length in baud ticks; double speed is expected off here
  assign link.bit_ticks = double_speed ? `BIT_TICKS_DOUBLE : `BIT_TICKS_NORMAL;
  // One tick per baud clock edge, sixteen per bit up to 115.2 kbit/s
  assign link.baud_tick = baud_tick;

  // ---------------------------------------------------------------
  // Receive source select
  // ---------------------------------------------------------------
  always_comb begin
    // Codes 1nnn pick a channel, others keep the pin
    ev_sel = s.src_sel[`SOURCE_SEL_CH_BIT];
    rx_src = ev_sel ? event_channel_n[s.src_sel[2:0]] : s.rx_sync;
    bypass = (s.tx_len == `TXLEN_BYPASS);
  end

  // ---------------------------------------------------------------
  // Pulse engines
  // ---------------------------------------------------------------
  ir_tx_shaper u_shaper (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(link),
    .usart_txd(usart_txd),
    .tx_pulse(tx_pulse)
  );

  // Pin low means pulse present
  ir_rx_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(link),
    .ir_level(!rx_src),
    .rx_bit(rx_bit)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Pin synchroniser
    next_s.rx_meta = rx_pin;
    next_s.rx_sync = s.rx_meta;
    // Register writes
    if (wr_en) begin
      case (reg_addr)
        `OFF_EVENT_SOURCE: begin
          next_s.src_sel = wr_data[`SOURCE_SEL_MSB:0];
        end
        `OFF_TX_PULSE_LENGTH: begin
          next_s.tx_len = wr_data;
        end
        `OFF_RX_FILTER_LENGTH: begin
          next_s.rx_len = wr_data;
        end
        default: begin
          // Unmapped offset ignores writes
        end
      endcase
    end
    // Register reads, data valid in the next cycle
    next_s.rd_data = 8'h00;
    if (rd_en) begin
      case (reg_addr)
        `OFF_EVENT_SOURCE: begin
          next_s.rd_data = {4'h0, s.src_sel};
        end
        `OFF_TX_PULSE_LENGTH: begin
          next_s.rd_data = s.tx_len;
        end
        `OFF_RX_FILTER_LENGTH: begin
          next_s.rd_data = s.rx_len;
        end
        default: begin
          next_s.rd_data = 8'h00;
        end
      endcase
    end
    // Pin and port routing
    if (!link.active) begin
      // Plain port wiring, settings unused
      next_s.tx_pin = usart_txd;
      next_s.usart_rxd = s.rx_sync;
    end else if (bypass) begin
      // Coding off, lines pass unaltered
      next_s.tx_pin = usart_txd;
      next_s.usart_rxd = rx_src;
    end else begin
      // Pin carries the inverse of the pulse
      next_s.tx_pin = !tx_pulse;
      next_s.usart_rxd = rx_bit;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // All settings clear to zero
      s <= '{src_sel: `EVENT_SOURCE_RST, tx_len: `LENGTH_RST, rx_len: `LENGTH_RST,
             rd_data: 8'h00, rx_meta: 1'b1, rx_sync: 1'b1, tx_pin: 1'b1, usart_rxd: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data = s.rd_data;
  assign tx_pin = s.tx_pin;
  assign usart_rxd = s.usart_rxd;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  plain_route_a: assert property (!link.active |=> tx_pin == $past(usart_txd) && usart_rxd == $past(s.rx_sync))
    else $error("plain routing broken");
  bypass_tx_a: assert property (link.active && bypass |=> tx_pin == $past(usart_txd))
    else $error("bypass transmit altered");
  pin_invert_a: assert property (link.active && !bypass |=> tx_pin == !$past(tx_pulse))
    else $error("transmit pin not inverted");
  event_input_a: assert property (link.active && bypass && ev_sel
    |=> usart_rxd == $past(event_channel_n[s.src_sel[2:0]])) else $error("event input not used");
  reserved_code_a: assert property (link.active && bypass && !ev_sel |=> usart_rxd == $past(s.rx_sync))
    else $error("reserved code left pin");
  source_upper_a: assert property (rd_en && reg_addr == 2'h0 |=> rd_data[7:4] == 4'h0)
    else $error("control upper bits not zero");
  reset_zero_a: assert property ($fell(sys_rst) |-> s.src_sel == 4'h0 && s.tx_len == 8'h00 && s.rx_len == 8'h00)
    else $error("registers not zero after reset");
  read_back_a: assert property (wr_en && reg_addr == 2'h1 ##1 rd_en && reg_addr == 2'h1 && !wr_en
    |=> rd_data == $past(wr_data, 2)) else $error("pulse length read back wrong");
  bypass_cov: cover property (link.active && bypass && ev_sel);
  ir_tx_cov: cover property (link.active && !bypass && $fell(tx_pin));
endmodule
`default_nettype wire

// ### tb/ir_transceiver_model.sv
// Behavioural infrared transceiver facing the codec's transmit and receive pins.
// Assumes one clock; a low pin level means light is present.
`default_nettype none
module ir_transceiver_model (
  input wire logic clk,
  input wire logic baud_tick,
  input wire logic tx_pin,
  input wire logic send_go,
  input wire logic [7:0] send_len,
  output logic rx_pin,
  output var int pulse_count,
  output var int last_width,
  output var int last_age
);
  timeunit 1ns;
  timeprecision 100ps;
  int age = 0; // Cycles since the last baud tick
  int run = 0; // Length of the low run now on tx_pin
  int cnt = 0; // Pulses seen so far
  int width = 0; // Width of the last finished pulse
  int lage = 0; // Tick age when the last pulse began
  logic [7:0] left = 8'h00; // Pulse cycles still to send
  logic tx_prev = 1'b1; // Pin level one cycle ago

  // Watch the transmit pin and shape the receive pin
  always @(posedge clk) begin
    age <= baud_tick ? 0 : age + 1;
    tx_prev <= tx_pin;
    if (tx_pin === 1'b0) begin // Low level is a pulse of light
      run <= run + 1;
      if (tx_prev === 1'b1) begin
        lage <= age;
      end
    end else if (run != 0) begin // Pulse over: record it
      width <= run;
      cnt <= cnt + 1;
      run <= 0;
    end
    if (send_go) begin
      left <= send_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  // Idle pin stays high; it is low only while light is sent
  assign rx_pin = (left == 8'h00);
  assign pulse_count = cnt;
  assign last_width = width;
  assign last_age = lage;
endmodule
`default_nettype wire

// ### tb/infrared_codec_tb.sv
// Self-checking bench for the infrared codec with a transceiver model on its pins.
// Assumes the codec and its package, interface and header are compiled first.
`default_nettype none
module infrared_codec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic [1:0] comm_mode_select = 2'h0;
  logic baud_tick = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic usart_txd = 1'b1;
  logic usart_rxd;
  logic tx_pin;
  logic rx_pin;
  logic [7:0] event_channel_n = 8'hFF;
  logic send_go = 1'b0;
  logic [7:0] send_len = 8'h00;
  int pulse_count;
  int last_width;
  int last_age;
  int n_errors = 0;
  int num_checks = 0;

  // Double speed stays cleared while infrared mode is in use
  infrared_codec dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .comm_mode_select(comm_mode_select),
    .double_speed(1'b0), .baud_tick(baud_tick), .usart_txd(usart_txd), .usart_rxd(usart_rxd),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .event_channel_n(event_channel_n));
  ir_transceiver_model partner_u (.clk(clk), .baud_tick(baud_tick), .tx_pin(tx_pin),
    .send_go(send_go), .send_len(send_len), .rx_pin(rx_pin), .pulse_count(pulse_count),
    .last_width(last_width), .last_age(last_age));

  // Clock and a baud tick every four cycles, sixteen ticks a bit
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    baud_tick <= (tcnt == 2'h3);
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // Counts cycles with the decoded line not high
  task automatic measure_rxd(input int n, output int w);
    w = 0;
    repeat (n) begin
      @(posedge clk);
      if (usart_rxd !== 1'b1) w++;
    end
  endtask

  task automatic pin_pulse(input logic [7:0] n);
    @(posedge clk);
    send_len <= n;
    send_go <= 1'b1;
    @(posedge clk);
    send_go <= 1'b0;
  endtask

  task automatic ev_pulse(input int ch, input int n);
    @(posedge clk);
    event_channel_n[ch] <= 1'b0;
    repeat (n) @(posedge clk);
    event_channel_n[ch] <= 1'b1;
  endtask

  // Sends nbits zero bits from a tick, then checks count, width and start
  task automatic run_tx(input logic [7:0] len, input int nbits, input int expw);
    int c0;
    int i;
    reg_wr(2'h1, len); // Length set before any transmission
    c0 = pulse_count;
    i = 0;
    while (baud_tick !== 1'b1 && i < 10) begin
      @(posedge clk);
      i++;
    end
    usart_txd <= 1'b0;
    repeat (64 * nbits) @(posedge clk);
    usart_txd <= 1'b1;
    i = 0;
    while (pulse_count < c0 + nbits && i < 100) begin
      @(posedge clk);
      i++;
    end
    chk(pulse_count == c0 + nbits, "pulse count");
    chk(last_width == expw, "pulse width");
    chk(last_age == 1, "pulse not on baud tick");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    logic [7:0] d;
    for (int a = 0; a < 3; a++) begin
      reg_rd(a[1:0], d);
      chk(d === 8'h00, "reset value");
    end
    reg_wr(2'h0, 8'hFF);
    reg_rd(2'h0, d);
    chk(d === 8'h0F, "control upper bits");
    reg_wr(2'h1, 8'hA5);
    reg_wr(2'h2, 8'h5A);
    reg_wr(2'h3, 8'h77);
    reg_rd(2'h1, d);
    chk(d === 8'hA5, "tx length readback");
    reg_rd(2'h2, d);
    chk(d === 8'h5A, "rx filter readback");
    reg_rd(2'h3, d);
    chk(d === 8'h00, "unmapped read");
    reg_wr(2'h0, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_tx();
    comm_mode_select <= 2'h2; // Only this port selects infrared
    run_tx(8'h01, 2, 1);
    run_tx(8'h04, 2, 4);
    run_tx(8'h00, 1, 12);
    run_tx(8'hFF, 1, 64);
    comm_mode_select <= 2'h0;
    run_tx(8'h04, 1, 64);
    $display("test tx done");
  endtask

  task automatic test_rx_event();
    int w;
    comm_mode_select <= 2'h2;
    reg_wr(2'h1, 8'h00);
    reg_wr(2'h2, 8'h02); // Filter set before reception
    for (int ch = 0; ch < 8; ch++) begin
      reg_wr(2'h0, 8'h08 | ch[7:0]);
      pin_pulse(8'h03);
      ev_pulse((ch + 1) % 8, 3);
      measure_rxd(120, w);
      chk(w == 0, "unselected source decoded");
      ev_pulse(ch, 2);
      measure_rxd(120, w);
      chk(w == 0, "short pulse accepted");
      ev_pulse(ch, 3);
      measure_rxd(120, w);
      chk(w >= 56 && w <= 72, "event pulse lost");
    end
    $display("test rx event done");
  endtask

  task automatic test_rx_pin();
    int w;
    reg_wr(2'h2, 8'h00);
    reg_wr(2'h0, 8'h00);
    pin_pulse(8'h01);
    measure_rxd(120, w);
    chk(w >= 56 && w <= 72, "unfiltered pin pulse lost");
    reg_wr(2'h0, 8'h01);
    pin_pulse(8'h01);
    measure_rxd(120, w);
    chk(w >= 56 && w <= 72, "reserved code blocks pin");
    reg_wr(2'h0, 8'h00);
    reg_wr(2'h1, 8'hFF);
    pin_pulse(8'h03);
    measure_rxd(120, w);
    chk(w == 3, "bypass receive width");
    comm_mode_select <= 2'h0;
    reg_wr(2'h1, 8'h04);
    reg_wr(2'h2, 8'h05);
    pin_pulse(8'h03);
    measure_rxd(120, w);
    chk(w == 3, "inactive receive width");
    $display("test rx pin done");
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    test_regs();
    test_tx();
    test_rx_event();
    test_rx_pin();
    tally_and_finish();
  end
endmodule
`default_nettype wire
